// [ehci_cap_pkg.sv]
// Purpose: constants and carrier types for the capability register bank
// Assumes: byte addressing from the controller memory base, 32-bit words
// Notes:   structural values other than the strapped indicator bit are fixed build choices of this core
package ehci_cap_pkg;

  // register byte offsets from the memory base
  localparam logic [7:0]  version_length_offset = 8'h00;
  localparam logic [7:0]  structural_offset     = 8'h04;

  // field positions, first capability word
  localparam int          version_lsb           = 16;
  localparam int          cap_length_lsb        = 0;

  // field positions, structural word
  localparam int          debug_port_lsb        = 20;
  localparam int          port_indicator_bit    = 16;
  localparam int          companion_count_lsb   = 12;
  localparam int          ports_per_comp_lsb    = 8;
  localparam int          routing_method_bit    = 7;
  localparam int          power_switch_bit      = 4;
  localparam int          port_count_lsb        = 0;

  // reset values of the read-only fields
  localparam logic [15:0] interface_version_bcd_value   = 16'h0100;
  localparam logic [7:0]  capability_block_length_value = 8'h20;
  localparam logic [3:0]  debug_port_index_value        = 4'h0;
  localparam logic [3:0]  companion_count_value         = 4'h2;
  localparam logic [3:0]  ports_per_companion_value     = 4'h2;
  localparam logic        port_routing_method_value     = 1'b1;
  localparam logic        port_power_switch_value       = 1'b1;
  localparam logic [3:0]  port_count_value              = 4'h4;

  // explicit routing table, nibble i is the companion of port i
  localparam logic [15:0][3:0] explicit_route_table =
    64'h0000_0000_0000_1100;

  localparam int          max_ports             = 16;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } reg_rsp_type;

  typedef struct packed {
    logic [3:0] debug_port_index;
    logic       port_indicator;
    logic [3:0] companion_controller_count;
    logic [3:0] ports_per_companion;
    logic       port_routing_method;
    logic       port_power_switch_present;
    logic [3:0] port_count;
  } struct_fields_type;

endpackage

// [ehci_capability_registers.sv]
// Purpose: read-only capability register bank of the high-speed host core
// Assumes: requests are synchronous to core_clk, one request per cycle
// Notes:   answers come one cycle after the request with ack high
//
// Behaviour
// - the top half of word 0 returns the bcd interface version.
// - the low byte of word 0 returns the capability block length.
// - word 0 is decoded at byte offset 0x00.
// - the structural word is decoded at offset 0x04 and is read-only.
// - structural bits 23..20 give the debug port, nonzero meaning present.
// - the debug port index never exceeds the downstream port count.
// - a set indicator bit enables a per-port indicator control field.
// - the indicator bit is latched from the amber strap during reset.
// - zero companions means no hand-off and high-speed only ports.
// - nonzero companions means hand-off to companions is available.
// - bits 11..8 give ports per companion, grouped in ascending order.
// - routing method 0 is group-wise, 1 uses the explicit routing table.
// - the port count is 1..15 and sets how many ports are addressable.
// - a set power switch bit makes each port power field functional.
`timescale 1ns/100ps
module ehci_capability_registers
  import ehci_cap_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  amber_led_three_strap,
  input  wire reg_req_type           reg_req,
  output      reg_rsp_type           reg_rsp,
  output      logic [15:0]           port_addressable,
  output      logic [15:0][3:0]      port_companion_map,
  output      logic                  port_indicator_enable,
  output      logic                  port_power_functional,
  output      logic                  companion_handoff_enable,
  output      logic                  high_speed_only,
  output      logic                  debug_port_present,
  output      logic [3:0]            debug_port_index,
  output      logic [7:0]            operational_base,
  output      logic                  port_count_invalid
);

  logic [1:0]         rst_sync_reg;
  logic               rst_core_n;
  logic               strap_window;
  logic               strap_reg;
  struct_fields_type  fields;
  logic [3:0]         debug_index_checked;
  logic [3:0]         companion_last;
  logic [31:0]        version_length_word;
  logic [31:0]        structural_parameters_word;
  logic [31:0]        version_length_mask;
  logic [31:0]        structural_mask;
  logic [31:0]        read_data_next;
  logic [15:0]        addressable_next;
  logic [15:0][3:0]   companion_map_next;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync_reg[1];
  assign strap_window = !rst_core_n;

  // strap is caught while the synchronised reset is still low; the async
  // path only clears it, since a flop must not load a pin under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= 1'b0;
    end else if (strap_window) begin
      strap_reg <= amber_led_three_strap;
    end
  end

  // a debug index beyond the port count is reported as no debug port
  always_comb begin
    if (debug_port_index_value > port_count_value) begin
      debug_index_checked = 4'h0;
    end else begin
      debug_index_checked = debug_port_index_value;
    end
  end

  always_comb begin
    fields.debug_port_index           = debug_index_checked;
    fields.port_indicator             = strap_reg;
    fields.companion_controller_count = companion_count_value;
    fields.ports_per_companion        = ports_per_companion_value;
    fields.port_routing_method        = port_routing_method_value;
    fields.port_power_switch_present  = port_power_switch_value;
    fields.port_count                 = port_count_value;
  end

  // highest companion index; zero companions leave every port unrouted
  always_comb begin
    if (fields.companion_controller_count == 4'h0) begin
      companion_last = 4'h0;
    end else begin
      companion_last = fields.companion_controller_count - 4'h1;
    end
  end

  // reserved ranges are built from zeros
  always_comb begin
    version_length_word = 32'h0000_0000;
    version_length_word[version_lsb +: 16] =
      interface_version_bcd_value;
    version_length_word[cap_length_lsb +: 8] =
      capability_block_length_value;
  end

  always_comb begin
    structural_parameters_word = 32'h0000_0000;
    structural_parameters_word[debug_port_lsb +: 4] =
      fields.debug_port_index;
    structural_parameters_word[port_indicator_bit] =
      fields.port_indicator;
    structural_parameters_word[companion_count_lsb +: 4] =
      fields.companion_controller_count;
    structural_parameters_word[ports_per_comp_lsb +: 4] =
      fields.ports_per_companion;
    structural_parameters_word[routing_method_bit] =
      fields.port_routing_method;
    structural_parameters_word[power_switch_bit] =
      fields.port_power_switch_present;
    structural_parameters_word[port_count_lsb +: 4] =
      fields.port_count;
  end

  // only documented field bits may reach the bus, so a slip in the word
  // assembly above can never leak into a reserved range
  always_comb begin
    version_length_mask = 32'h0000_0000;
    version_length_mask[version_lsb +: 16]   = 16'hffff;
    version_length_mask[cap_length_lsb +: 8] = 8'hff;
  end

  always_comb begin
    structural_mask = 32'h0000_0000;
    structural_mask[debug_port_lsb +: 4]      = 4'hf;
    structural_mask[port_indicator_bit]       = 1'b1;
    structural_mask[companion_count_lsb +: 4] = 4'hf;
    structural_mask[ports_per_comp_lsb +: 4]  = 4'hf;
    structural_mask[routing_method_bit]       = 1'b1;
    structural_mask[power_switch_bit]         = 1'b1;
    structural_mask[port_count_lsb +: 4]      = 4'hf;
  end

  // address decode; unmapped offsets read as zero
  always_comb begin
    unique case (reg_req.addr)
      version_length_offset: read_data_next =
        version_length_word & version_length_mask;
      structural_offset:     read_data_next =
        structural_parameters_word & structural_mask;
      default:               read_data_next = 32'h0000_0000;
    endcase
  end

  // writes are acknowledged and dropped; nothing here has a read effect
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack <= reg_req.rd | reg_req.wr;
      if (reg_req.rd) begin
        reg_rsp.rdata <= read_data_next;
      end else begin
        reg_rsp.rdata <= 32'h0000_0000;
      end
    end
  end

  // per-port addressability and companion routing
  for (genvar p = 0; p < max_ports; p++) begin : g_port
    localparam logic [3:0] port_number = 4'(p);
    logic [3:0] group_index;
    logic [3:0] route_choice;

    always_comb begin
      if (fields.ports_per_companion == 4'h0) begin
        group_index = 4'h0;
      end else begin
        group_index = port_number / fields.ports_per_companion;
      end
    end

    // a route past the last companion would strand the port, so it is
    // pinned to the last companion; consistent settings never hit this
    always_comb begin
      if (fields.port_routing_method) begin
        route_choice = explicit_route_table[p];
      end else begin
        route_choice = group_index;
      end
      if (route_choice > companion_last) begin
        route_choice = companion_last;
      end
    end

    always_comb begin
      // port p exists when its number is below the port count
      addressable_next[p] = (fields.port_count != 4'h0) &&
                            (port_number < fields.port_count);
      if ((fields.companion_controller_count == 4'h0) ||
          !addressable_next[p]) begin
        companion_map_next[p] = 4'h0;
      end else begin
        companion_map_next[p] = route_choice;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      port_addressable <= 16'h0000;
    end else begin
      port_addressable <= addressable_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      port_companion_map <= '0;
    end else begin
      port_companion_map <= companion_map_next;
    end
  end

  // capability flags that steer the port registers and ownership logic
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      port_indicator_enable <= 1'b0;
    end else begin
      port_indicator_enable <= fields.port_indicator;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      port_power_functional <= 1'b0;
    end else begin
      port_power_functional <= fields.port_power_switch_present;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      companion_handoff_enable <= 1'b0;
    end else begin
      companion_handoff_enable <=
        (fields.companion_controller_count != 4'h0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      high_speed_only <= 1'b0;
    end else begin
      high_speed_only <=
        (fields.companion_controller_count == 4'h0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      debug_port_present <= 1'b0;
    end else begin
      debug_port_present <= (fields.debug_port_index != 4'h0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      debug_port_index <= 4'h0;
    end else begin
      debug_port_index <= fields.debug_port_index;
    end
  end

  // software adds this to the memory base to reach the operational space
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      operational_base <= 8'h00;
    end else begin
      operational_base <= capability_block_length_value;
    end
  end

  // zero ports is undefined; it is flagged rather than silently used
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      port_count_invalid <= 1'b0;
    end else begin
      port_count_invalid <= (fields.port_count == 4'h0);
    end
  end

endmodule

// [ehci_capability_registers_chk.sv]
// Purpose: port-level assertions for the capability register bank
// Assumes: outputs are valid once operational_base shows the block length
// Notes:   one clock domain, so default clocking and disable are used
`timescale 1ns/100ps
module ehci_capability_registers_chk
  import ehci_cap_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire reg_req_type      reg_req,
  input wire reg_rsp_type      reg_rsp,
  input wire logic [15:0]      port_addressable,
  input wire logic [15:0][3:0] port_companion_map,
  input wire logic             port_indicator_enable,
  input wire logic             port_power_functional,
  input wire logic             companion_handoff_enable,
  input wire logic             high_speed_only,
  input wire logic             debug_port_present,
  input wire logic [3:0]       debug_port_index,
  input wire logic [7:0]       operational_base,
  input wire logic             port_count_invalid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // status outputs read zero until the third edge after release
  logic settled;
  assign settled = operational_base == capability_block_length_value;
  sequence s_req;
    reg_req.rd || reg_req.wr;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  property p_ack;
    s_req |=> reg_rsp.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("missing ack");
  property p_idle;
    !(reg_req.rd || reg_req.wr) |=> !reg_rsp.ack;
  endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_word0;
    s_rd(8'h00) |=> reg_rsp.rdata == {interface_version_bcd_value, 8'h00,
      capability_block_length_value};
  endproperty
  a_word0: assert property (p_word0) else $error("word 0");
  property p_word1;
    s_rd(8'h04) |=> reg_rsp.rdata == {15'h0000, port_indicator_enable,
      16'h2294};
  endproperty
  a_word1: assert property (p_word1) else $error("word 1");
  property p_write;
    reg_req.wr && !reg_req.rd |=> reg_rsp.rdata == 32'h0000_0000;
  endproperty
  a_write: assert property (p_write) else $error("write data");
  property p_hole;
    reg_req.rd && reg_req.addr != 8'h00 && reg_req.addr != 8'h04
      |=> reg_rsp.rdata == 32'h0000_0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read");
  property p_debug;
    settled |-> debug_port_index <= port_count_value
      && debug_port_present == (debug_port_index != 4'h0);
  endproperty
  a_debug: assert property (p_debug) else $error("debug port");
  property p_struct;
    settled |-> port_companion_map == explicit_route_table
      && port_addressable == 16'h000f && !port_count_invalid;
  endproperty
  a_struct: assert property (p_struct) else $error("map");
  property p_caps;
    settled |-> port_power_functional && companion_handoff_enable
      && !high_speed_only;
  endproperty
  a_caps: assert property (p_caps) else $error("caps");
  property p_strap;
    settled && $past(settled) |-> $stable(port_indicator_enable);
  endproperty
  a_strap: assert property (p_strap) else $error("strap moved");
endmodule

bind ehci_capability_registers ehci_capability_registers_chk i_chk (.*);

// [tb_ehci_capability_registers.sv]
// Purpose: directed register reads and writes of the capability bank
// Assumes: one request at a time, answer one cycle after it is taken
// Notes:   a second reset with the strap high checks the latched bit
`timescale 1ns/100ps
module tb_ehci_capability_registers;
  import ehci_cap_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             amber_led_three_strap = 1'b0;
  reg_req_type      reg_req = '0;
  reg_rsp_type      reg_rsp;
  logic [15:0]      port_addressable;
  logic [15:0][3:0] port_companion_map;
  logic             port_indicator_enable, port_power_functional;
  logic             companion_handoff_enable, high_speed_only;
  logic             debug_port_present, port_count_invalid;
  logic [3:0]       debug_port_index;
  logic [7:0]       operational_base;
  logic [7:0]       holes [3] = '{8'h01, 8'h08, 8'hff};
  logic [31:0]      word0;
  int               mismatches = 0;
  int               checked = 0;
  int               cycles = 0;
  always #4 core_clk = ~core_clk;
  ehci_capability_registers i_dut (.core_clk, .rst_n, .amber_led_three_strap,
    .reg_req, .reg_rsp, .port_addressable, .port_companion_map,
    .port_indicator_enable, .port_power_functional, .companion_handoff_enable,
    .high_speed_only, .debug_port_present, .debug_port_index,
    .operational_base, .port_count_invalid);
  assign word0 = {interface_version_bcd_value, 8'h00,
    capability_block_length_value};
  function automatic logic [31:0] word1(input logic s);
    return {8'h00, debug_port_index_value, 3'b000, s, companion_count_value,
      ports_per_companion_value, port_routing_method_value, 2'b00,
      port_power_switch_value, port_count_value};
  endfunction
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                        input logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= '{rd, wr, a, 32'hffff_ffff};
    @(posedge core_clk);
    reg_req <= '0;
    @(negedge core_clk);
    cmp(64'(reg_rsp.ack), 64'h1);
    cmp(64'(reg_rsp.rdata), 64'(exp));
  endtask
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    rst_n <= 1'b0;
    amber_led_three_strap <= s;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic check_status(input logic s);
    cmp(64'(operational_base), 64'(capability_block_length_value));
    cmp(64'(port_addressable), 64'h000f);
    cmp(64'(port_companion_map), 64'(explicit_route_table));
    cmp(64'({companion_handoff_enable, high_speed_only, port_power_functional,
      port_count_invalid}), 64'ha);
    cmp(64'({debug_port_present, debug_port_index}), 64'h0);
    cmp(64'(port_indicator_enable), 64'(s));
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    do_reset(1'b0);
    check_status(1'b0);
    access(1'b1, 1'b0, version_length_offset, word0);
    access(1'b1, 1'b0, structural_offset, word1(1'b0));
    access(1'b0, 1'b1, structural_offset, 32'h0000_0000);
    access(1'b0, 1'b1, version_length_offset, 32'h0000_0000);
    access(1'b1, 1'b1, version_length_offset, word0);
    foreach (holes[i]) access(1'b1, 1'b0, holes[i], 32'h0000_0000);
    access(1'b1, 1'b0, structural_offset, word1(1'b0));
    @(posedge core_clk);
    amber_led_three_strap <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_status(1'b0);
    do_reset(1'b1);
    check_status(1'b1);
    access(1'b1, 1'b0, structural_offset, word1(1'b1));
    results();
  end
endmodule
